// ==== dv/acq_link_props.sv ====
// link handshake and busy timing checks for the acquisition link
`timescale 1ns/1ps
module acq_link_props (
   // clock and reset
   input wire logic        pclk,
   input wire logic        presetn,
   // link
   input wire logic        req,
   input wire logic        wr,
   input wire logic [15:0] addr,
   input wire logic [31:0] wdata,
   input wire logic        ack,
   input wire logic        berr,
   input wire logic [63:0] rdata,
   // front end
   input wire logic        com,
   input wire logic        fast_clear,
   input wire logic        busy
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_taken; req && !ack; endsequence
   sequence s_start; com && !busy && !fast_clear; endsequence
   a_ack_next: assert property (s_taken |=> ack) else $error("no ack");
   a_ack_pulse: assert property (ack |=> !ack) else $error("ack too long");
   a_berr_ack: assert property (berr |-> ack) else $error("berr alone");
   a_ack_cause: assert property (ack |-> $past(req) && !$past(ack))
      else $error("ack unasked");
   a_req_holds: assert property (s_taken |=> req && $stable(addr) && $stable(wdata)
      && $stable(wr)) else $error("request moved");
   a_req_release: assert property (ack |=> !req) else $error("req kept");
   a_rdata_held: assert property (!$stable(rdata) |-> ack) else $error("rdata moved");
   a_busy_start: assert property (s_start |-> ##[1:2] busy) else $error("no busy");
   // a fast clear legally ends the conversion early, so it cancels both checks below
   a_busy_stays: assert property (disable iff (!presetn || fast_clear)
      $rose(busy) |-> ##140 busy) else $error("busy fell early");
   a_busy_ends: assert property (disable iff (!presetn || fast_clear)
      $rose(busy) |-> ##[141:400] !busy) else $error("busy stuck");
endmodule

// ==== dv/test_event_acquisition_buffer_sequencer.sv ====
// self-checking bench joining the bus master end and the acquisition device
`timescale 1ns/1ps
module test_event_acquisition_buffer_sequencer import acq_pkg::*; ;
   logic              pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
   logic              com, fast_clear, busy;
   logic [7:0]        paddr;
   logic [31:0]       pwdata, prdata, rd, st;
   logic [31:0][13:0] ch_data;
   int                fail_count, checks, cyc;
   acq_link_if lnk ();
   acq_device acq_device_i (.pclk, .presetn, .lnk, .com, .fast_clear, .ch_data, .busy);
   acq_host acq_host_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .lnk);
   acq_link_props acq_link_props_i (.pclk, .presetn, .req(lnk.req), .wr(lnk.wr), .addr(lnk.addr),
      .wdata(lnk.wdata), .ack(lnk.ack), .berr(lnk.berr), .rdata(lnk.rdata), .com, .fast_clear,
      .busy);
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks++;
      if (g !== e) begin
         fail_count++;
         $display("Error %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk) {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
      @(posedge pclk) penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // status is read once, so a refused command returns too
   task automatic cmd(input logic w, input logic [15:0] a, input logic [31:0] d);
      apb(1'b1, H_ADDR, {16'h0000, a});
      apb(1'b1, H_WDATA, d);
      apb(1'b1, H_CMD, {31'h0, w});
      apb(1'b0, H_STATUS, 32'h0);
   endtask
   // one device access through the master; waits on its done flag
   task automatic dev(input logic w, input logic [15:0] a, input logic [31:0] d);
      cmd(w, a, d);
      while (rd[4] !== 1'b1) apb(1'b0, H_STATUS, 32'h0);
      st = rd;
      apb(1'b0, H_RD_LO, 32'h0);
   endtask
   task automatic rdb();
      dev(1'b0, 16'h0000, 32'h0);
   endtask
   task automatic trig();
      @(posedge pclk) com <= 1'b1;
      @(posedge pclk) com <= 1'b0;
   endtask
   task automatic conv();
      trig();
      repeat (3) @(posedge pclk);
      while (busy !== 1'b0) @(posedge pclk);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_bus();
      apb(1'b0, 8'hfc, 32'h0);
      chk(er, 1'b1);
      $display("t_bus finished");
   endtask
   task automatic t_conv();
      trig();
      repeat (20) @(posedge pclk);
      conv();
      dev(1'b0, 16'h0000, 32'h0);
      chk(rd, 32'h02002000);
      for (int i = 0; i < CHANNELS; i++) begin
         dev(1'b0, 16'h0000, 32'h0);
         chk({rd[26:24], rd[12:0]}, {WT_DATA, 13'h0800});
      end
      dev(1'b0, 16'h0000, 32'h0);
      chk(rd[26:24], WT_EOB);
      dev(1'b0, 16'h0000, 32'h0);
      chk(rd, NOT_VALID_WORD);
      dev(1'b0, OFF_EVT_CNT, 32'h0);
      chk(rd[23:0], 24'h000001);
      dev(1'b1, OFF_CTRL1, 32'h20);
      dev(1'b0, 16'h0000, 32'h0);
      chk(st[5], 1'b1);
      dev(1'b1, OFF_CTRL1, 32'h0);
      $display("t_conv finished");
   endtask
   task automatic t_empty();
      dev(1'b1, OFF_THRESHOLD, 32'hff);
      conv();
      dev(1'b0, 16'h0000, 32'h0);
      chk(rd, NOT_VALID_WORD);
      dev(1'b1, OFF_BSET2, 32'h1000);
      conv();
      dev(1'b0, 16'h0000, 32'h0);
      chk(rd, 32'h02000000);
      dev(1'b0, 16'h0000, 32'h0);
      chk(rd[26:24], WT_EOB);
      dev(1'b1, OFF_BCLR2, 32'h1000);
      dev(1'b1, OFF_THRESHOLD, 32'h0);
      $display("t_empty finished");
   endtask
   task automatic t_abort();
      trig();
      repeat (20) @(posedge pclk);
      fast_clear <= 1'b1;
      @(posedge pclk) fast_clear <= 1'b0;
      dev(1'b0, 16'h0000, 32'h0);
      chk(rd, NOT_VALID_WORD);
      $display("t_abort finished");
   endtask
   task automatic t_mem();
      dev(1'b1, OFF_BSET2, 32'h1);
      dev(1'b1, OFF_W_TEST_ADDR, 32'h10);
      dev(1'b1, OFF_TEST_HIGH, 32'hbeef);
      dev(1'b1, OFF_TEST_LOW, 32'hcafe);
      dev(1'b1, OFF_W_TEST_ADDR, 32'h20);
      cmd(1'b1, OFF_R_TEST_ADDR, 32'h20);
      chk(rd[6:4], 3'h4);
      dev(1'b1, OFF_R_TEST_ADDR, 32'h10);
      rdb();
      chk(rd, 32'hbeefcafe);
      dev(1'b1, OFF_BCLR2, 32'h1);
      $display("t_mem finished");
   endtask
   // runs last, so the modes it leaves set need no undoing
   task automatic t_acq();
      dev(1'b1, OFF_SW_RESET, 32'h0);
      cmd(1'b1, OFF_BSET2, 32'h40);
      chk(rd[6:4], 3'h4);
      dev(1'b1, OFF_BSET2, 32'h20);
      dev(1'b1, OFF_BSET2, 32'h40);
      cmd(1'b1, OFF_TEST_EVENT, 32'h0);
      chk(rd[6:4], 3'h4);
      dev(1'b1, OFF_BCLR2, 32'h40);
      for (int k = 0; k < 32; k++) dev(1'b1, OFF_TEST_EVENT, 32'h100 + k);
      chk(st[7], 1'b1);
      dev(1'b1, OFF_BSET2, 32'h40);
      conv();
      conv();
      dev(1'b1, OFF_CTRL1, 32'h4);
      apb(1'b1, H_MODE, 32'h1);
      rdb();
      chk(rd, 32'h02002000);
      for (int k = 0; k < 32; k++) begin
         rdb();
         chk({rd[20:16], rd[12:0]}, {5'(k % 2 * 16 + k / 2), 13'(k + 256)});
      end
      rdb();
      chk(rd[26:24], WT_EOB);
      rdb();
      chk(rd, NOT_VALID_WORD);
      apb(1'b1, H_MODE, 32'h2);
      rdb();
      apb(1'b0, H_RD_HI, 32'h0);
      chk(rd, 32'h00000100);
      $display("t_acq finished");
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         fail_count++;
         $display("Error %0t: timeout", $time);
         complete_run();
      end
   end
   initial begin
      {presetn, psel, penable, pwrite, com, fast_clear, paddr, pwdata} = '0;
      for (int c = 0; c < CHANNELS; c++) ch_data[c] = 14'h0800;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      t_bus();
      t_conv();
      t_empty();
      t_abort();
      t_mem();
      t_acq();
      complete_run();
   end
endmodule

// ==== src/acq_device.sv ====
// acquisition device: conversion sequencer, event buffer, test modes and buffer readout
//
// Design decision made here: the req/ack register link to the registers.
`timescale 1ns/1ps
module acq_device
   import acq_pkg::*;
(
   // clock and reset
   input  wire logic             pclk,
   input  wire logic             presetn,
   // register link
   acq_link_if.dev               lnk,
   // front end
   input  wire logic             com,
   input  wire logic             fast_clear,
   input  wire logic [31:0][13:0] ch_data,
   output logic                  busy
);
   ////////////////////////////////////////////////////////////////////////////////
   // storage and state
   seq_state_t    state_reg, state_next;
   logic [7:0]    tac_cnt_reg;
   logic [4:0]    slot_reg;
   logic [5:0]    acc_cnt_reg, out_idx_reg;
   logic [31:0]   acc_mem [CHANNELS];
   logic [31:0]   multi_event_buffer [MEB_DEPTH];
   logic [13:0]   tf_mem [CHANNELS];
   logic [AW-1:0] wp_reg, rp_reg, w_addr_reg, r_addr_reg;
   logic [AW:0]   used_reg;
   logic [23:0]   evt_cnt_reg;
   logic [15:0]   bset2_reg, ctrl1_reg, test_high_reg;
   logic [7:0]    thr_reg;
   logic [31:0]   kill_reg;
   logic [4:0]    tf_wp_reg, tf_rp_reg;
   logic          block_done_reg, ack_reg, berr_reg;
   logic [63:0]   rdata_reg;

   // channels are visited 0,16,1,17,...,15,31
   function automatic logic [4:0] slot_chan(input logic [4:0] s);
      return {s[0], s[4:1]};
   endfunction

   function automatic logic hit(input logic [15:0] a, input logic [15:0] o);
      return a == o;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // link decode
   wire take      = lnk.req & ~ack_reg;
   wire wr_hit    = take & lnk.wr;
   wire buf_rd    = take & ~lnk.wr & (lnk.addr <= OFF_BUFFER_LAST);
   wire sw_reset  = wr_hit & hit(lnk.addr, OFF_SW_RESET);
   wire mem_test  = bset2_reg[B2_MEM_TEST];
   wire acq_test  = bset2_reg[B2_ACQ_TEST];
   wire acq_set   = wr_hit & hit(lnk.addr, OFF_BSET2) & lnk.wdata[B2_ACQ_TEST];
   wire acq_clr   = wr_hit & hit(lnk.addr, OFF_BCLR2) & lnk.wdata[B2_ACQ_TEST];
   wire tf_wr     = wr_hit & hit(lnk.addr, OFF_TEST_EVENT) & ~acq_test;
   wire meb_full  = used_reg > MEB_FULL_LEVEL;

   ////////////////////////////////////////////////////////////////////////////////
   // conversion decisions
   wire        start   = com & (state_reg == S_IDLE) & ~meb_full & ~sw_reset;
   wire        abort   = (fast_clear & (state_reg == S_TAC)) |
                         (sw_reset & (state_reg != S_IDLE));
   wire [4:0]  ch      = slot_chan(slot_reg);
   // test mode replays the fifo in the same interleaved slot order
   wire [13:0] sample  = acq_test ? tf_mem[tf_rp_reg] : ch_data[ch];
   wire        zero_ok = bset2_reg[B2_ZERO_SUP_OFF] | (sample[11:4] >= thr_reg);
   wire        ovf_ok  = bset2_reg[B2_OVF_SUP_OFF] | ~sample[13];
   wire        accept  = acq_test | (~kill_reg[ch] & zero_ok & ovf_ok);
   wire [31:0] data_w  = {5'h00, WT_DATA, 3'h0, ch, 1'b0, sample[13], 1'b0, sample[12:0]};
   wire        keep    = (acc_cnt_reg != 6'h00) | bset2_reg[B2_EMPTY_WRITE];
   wire [31:0] hdr_w   = {5'h00, WT_HEADER, 10'h000, acc_cnt_reg, 8'h00};
   wire [31:0] eob_w   = {5'h00, WT_EOB, evt_cnt_reg};
   wire        data_go = (state_reg == S_DATA) & (out_idx_reg != acc_cnt_reg);
   wire        st_we   = ((state_reg == S_HDR) & keep) | data_go | (state_reg == S_EOB);
   wire [31:0] st_w    = (state_reg == S_HDR) ? hdr_w :
                         (state_reg == S_DATA) ? acc_mem[out_idx_reg[4:0]] : eob_w;
   // a test word that collides with event storing is dropped; test mode assumes no triggers
   wire        tw_we   = wr_hit & hit(lnk.addr, OFF_TEST_LOW) & mem_test & ~st_we;

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         S_IDLE:  if (start) state_next = S_TAC;
         S_TAC: begin
            if (abort) state_next = S_CLEAR;
            else if (tac_cnt_reg == TAC_CYCLES - 8'h01) state_next = S_DIGI;
         end
         S_DIGI:  if (abort) state_next = S_CLEAR;
                  else if (slot_reg == 5'h1f) state_next = S_HDR;
         S_HDR:   state_next = (keep & ~abort) ? S_DATA : S_CLEAR;
         S_DATA:  if (abort) state_next = S_CLEAR;
                  else if (!data_go) state_next = S_EOB;
         S_EOB:   state_next = S_CLEAR;
         S_CLEAR: state_next = S_IDLE;
         default: state_next = S_IDLE;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////////
   // readout selection
   wire [31:0] w0       = multi_event_buffer[rp_reg];
   wire [31:0] w1       = multi_event_buffer[rp_reg + 11'h001];
   wire        blk_end  = ctrl1_reg[C1_BLOCK_END] & lnk.blt;
   wire        avail0   = (used_reg != 12'h000) & ~(block_done_reg & lnk.blt);
   wire        end0     = avail0 & (w0[26:24] == WT_EOB) & blk_end;
   wire        avail1   = lnk.wide & avail0 & (used_reg > 12'h001) & ~end0;
   wire        end1     = avail1 & (w1[26:24] == WT_EOB) & blk_end;
   wire        do_pop   = buf_rd & ~mem_test;
   wire [1:0]  pops     = do_pop ? ({1'b0, avail0} + {1'b0, avail1}) : 2'h0;
   wire        berr_now = do_pop & ~avail0 & ctrl1_reg[C1_BUS_ERROR];
   wire [31:0] rd_lo    = mem_test ? multi_event_buffer[r_addr_reg] : (avail0 ? w0 : NOT_VALID_WORD);
   wire [31:0] rd_hi    = avail1 ? w1 : NOT_VALID_WORD;
   logic [31:0] reg_w;

   always_comb begin
      case (lnk.addr)
         OFF_STATUS:      reg_w = {28'h0000000, acq_test, meb_full, used_reg != 12'h000, busy};
         OFF_CTRL1:       reg_w = {16'h0000, ctrl1_reg};
         OFF_EVT_CNT:     reg_w = {8'h00, evt_cnt_reg};
         OFF_BSET2:       reg_w = {16'h0000, bset2_reg};
         OFF_THRESHOLD:   reg_w = {24'h000000, thr_reg};
         OFF_KILL_MASK:   reg_w = kill_reg;
         OFF_W_TEST_ADDR: reg_w = {21'h000000, w_addr_reg};
         default:         reg_w = 32'h00000000;
      endcase
   end

   assign lnk.ack   = ack_reg;
   assign lnk.berr  = berr_reg;
   assign lnk.rdata = rdata_reg;

   ////////////////////////////////////////////////////////////////////////////////
   // link answer, one cycle after the request is taken
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ack_reg   <= 1'b0;
         berr_reg  <= 1'b0;
         rdata_reg <= 64'h0000000000000000;
      end else begin
         ack_reg  <= take;
         berr_reg <= berr_now;
         if (take) rdata_reg <= buf_rd ? {rd_hi, rd_lo} : {32'h00000000, reg_w};
      end
   end

   // configuration registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bset2_reg     <= BSET2_RESET;
         ctrl1_reg     <= CTRL1_RESET;
         thr_reg       <= THR_RESET;
         kill_reg      <= 32'h00000000;
         w_addr_reg    <= 11'h000;
         r_addr_reg    <= 11'h000;
         test_high_reg <= 16'h0000;
      end else if (wr_hit) begin
         case (lnk.addr)
            OFF_BSET2:       bset2_reg     <= bset2_reg | lnk.wdata[15:0];
            OFF_BCLR2:       bset2_reg     <= bset2_reg & ~lnk.wdata[15:0];
            OFF_CTRL1:       ctrl1_reg     <= lnk.wdata[15:0];
            OFF_THRESHOLD:   thr_reg       <= lnk.wdata[7:0];
            OFF_KILL_MASK:   kill_reg      <= lnk.wdata;
            OFF_W_TEST_ADDR: w_addr_reg    <= lnk.wdata[AW-1:0];
            OFF_R_TEST_ADDR: r_addr_reg    <= lnk.wdata[AW-1:0];
            OFF_TEST_HIGH:   test_high_reg <= lnk.wdata[15:0];
            default:         ;
         endcase
      end
   end

   // test fifo pointers wrap at 32, so extra words overwrite and short loads leave stale ones
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tf_wp_reg <= 5'h00;
         tf_rp_reg <= 5'h00;
      end else begin
         if (acq_set) tf_wp_reg <= 5'h00;
         else if (tf_wr) tf_wp_reg <= tf_wp_reg + 5'h01;
         if (acq_clr) tf_rp_reg <= 5'h00;
         else if (acq_test & (state_reg == S_DIGI)) tf_rp_reg <= tf_rp_reg + 5'h01;
      end
   end

   // memories carry no reset
   always_ff @(posedge pclk) begin
      if (tf_wr) tf_mem[tf_wp_reg] <= lnk.wdata[13:0];
      if ((state_reg == S_DIGI) & accept) acc_mem[acc_cnt_reg[4:0]] <= data_w;
      if (st_we) multi_event_buffer[wp_reg] <= st_w;
      else if (tw_we) multi_event_buffer[w_addr_reg] <= {test_high_reg, lnk.wdata[15:0]};
   end

   ////////////////////////////////////////////////////////////////////////////////
   // sequencer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg   <= S_IDLE;
         tac_cnt_reg <= 8'h00;
         slot_reg    <= 5'h00;
         acc_cnt_reg <= 6'h00;
         out_idx_reg <= 6'h00;
         busy        <= 1'b0;
      end else begin
         state_reg <= state_next;
         busy      <= (state_next != S_IDLE) | meb_full;
         if (state_reg == S_TAC) tac_cnt_reg <= tac_cnt_reg + 8'h01;
         else tac_cnt_reg <= 8'h00;
         if (start) begin
            slot_reg    <= 5'h00;
            acc_cnt_reg <= 6'h00;
            out_idx_reg <= 6'h00;
         end
         if (state_reg == S_DIGI) begin
            slot_reg <= slot_reg + 5'h01;
            if (accept) acc_cnt_reg <= acc_cnt_reg + 6'h01;
         end
         if (data_go) out_idx_reg <= out_idx_reg + 6'h01;
      end
   end

   // buffer pointers, fill level, block stop and event counter
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wp_reg         <= 11'h000;
         rp_reg         <= 11'h000;
         used_reg       <= 12'h000;
         block_done_reg <= 1'b0;
         evt_cnt_reg    <= 24'h000000;
      end else if (sw_reset) begin
         wp_reg         <= 11'h000;
         rp_reg         <= 11'h000;
         used_reg       <= 12'h000;
         block_done_reg <= 1'b0;
      end else begin
         if (st_we) wp_reg <= wp_reg + 11'h001;
         rp_reg   <= rp_reg + {9'h000, pops};
         used_reg <= used_reg + {11'h000, st_we} - {10'h000, pops};
         if (take & ~lnk.blt) block_done_reg <= 1'b0;
         else if (do_pop & (end0 | end1)) block_done_reg <= 1'b1;
         if ((start & bset2_reg[B2_COUNT_ALL]) |
             ((state_reg == S_HDR) & keep & ~bset2_reg[B2_COUNT_ALL]))
            evt_cnt_reg <= evt_cnt_reg + 24'h000001;
      end
   end
endmodule

// ==== src/acq_host.sv ====
// bus master end: apb command registers driving the device register link
`timescale 1ns/1ps
module acq_host
   import acq_pkg::*;
(
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // device link
   acq_link_if.host         lnk
);
   logic [1:0]    mode_reg;
   logic [15:0]   addr_reg;
   logic [31:0]   wdata_reg;
   logic [63:0]   rd_reg;
   logic          req_reg, wr_reg, berr_reg, done_reg, refused_reg;
   logic          sh_valid_reg, sh_acq_reg;
   logic [AW-1:0] sh_w_reg, sh_r_reg;
   logic [5:0]    tf_cnt_reg;
   logic [31:0]   rd_mux;

   ////////////////////////////////////////////////////////////////////////////////
   // apb decode: one wait state, data captured in the first access cycle
   wire capture = psel & penable & ~pready;
   wire commit  = psel & penable & pready & pwrite;
   wire cmd_go  = commit & (paddr == H_CMD) & ~req_reg;
   wire op_wr   = pwdata[0];
   wire hit_any = (paddr == H_MODE) | (paddr == H_CMD) | (paddr == H_ADDR) |
                  (paddr == H_WDATA) | (paddr == H_RD_LO) | (paddr == H_RD_HI) |
                  (paddr == H_STATUS);

   // writes that would break the device test procedures are not issued
   wire bad_w  = (addr_reg == OFF_W_TEST_ADDR) & (wdata_reg[AW-1:0] == sh_r_reg);
   wire bad_r  = (addr_reg == OFF_R_TEST_ADDR) & (wdata_reg[AW-1:0] == sh_w_reg);
   wire bad_a  = (addr_reg == OFF_BSET2) & wdata_reg[B2_ACQ_TEST] & ~sh_valid_reg;
   wire bad_t  = (addr_reg == OFF_TEST_EVENT) & sh_acq_reg;
   wire refuse = op_wr & (bad_w | bad_r | bad_a | bad_t);
   wire issue  = cmd_go & ~refuse;

   always_comb begin
      case (paddr)
         H_MODE:   rd_mux = {30'h00000000, mode_reg};
         H_ADDR:   rd_mux = {16'h0000, addr_reg};
         H_WDATA:  rd_mux = wdata_reg;
         H_RD_LO:  rd_mux = rd_reg[31:0];
         H_RD_HI:  rd_mux = rd_reg[63:32];
         H_STATUS: rd_mux = {24'h000000, tf_cnt_reg == TEST_EVENT_WORDS, refused_reg,
                             berr_reg, done_reg, req_reg, 3'h0};
         default:  rd_mux = 32'h00000000;
      endcase
   end

   assign lnk.req   = req_reg;
   assign lnk.wr    = wr_reg;
   assign lnk.blt   = mode_reg[HM_BLT];
   assign lnk.wide  = mode_reg[HM_WIDE];
   assign lnk.addr  = addr_reg;
   assign lnk.wdata = wdata_reg;

   ////////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h00000000;
      end else begin
         pready  <= capture;
         pslverr <= capture & ~hit_any;
         prdata  <= (capture & ~pwrite) ? rd_mux : 32'h00000000;
      end
   end

   // mode, address and data stay fixed while a request is pending
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_reg  <= 2'h0;
         addr_reg  <= 16'h0000;
         wdata_reg <= 32'h00000000;
      end else if (commit & ~req_reg) begin
         if (paddr == H_MODE) mode_reg <= pwdata[1:0];
         if (paddr == H_ADDR) addr_reg <= pwdata[15:0];
         if (paddr == H_WDATA) wdata_reg <= pwdata;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         req_reg     <= 1'b0;
         wr_reg      <= 1'b0;
         rd_reg      <= 64'h0000000000000000;
         berr_reg    <= 1'b0;
         done_reg    <= 1'b0;
         refused_reg <= 1'b0;
      end else begin
         if (issue) begin
            req_reg <= 1'b1;
            wr_reg  <= op_wr;
         end else if (lnk.ack) begin
            req_reg <= 1'b0;
         end
         if (cmd_go) refused_reg <= refuse;
         // completion flag: a new ack wins over the clear from the next command
         if (lnk.ack) done_reg <= 1'b1;
         else if (cmd_go) done_reg <= 1'b0;
         if (lnk.ack) begin
            berr_reg <= lnk.berr;
            if (!wr_reg) rd_reg <= lnk.rdata;
         end
      end
   end

   // shadows of the device test setup, updated as writes are issued
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sh_valid_reg <= 1'b0;
         sh_acq_reg   <= 1'b0;
         sh_w_reg     <= 11'h000;
         sh_r_reg     <= 11'h7ff;
         tf_cnt_reg   <= 6'h00;
      end else if (issue & op_wr) begin
         case (addr_reg)
            OFF_BSET2: begin
               if (wdata_reg[B2_VALID_CTRL]) sh_valid_reg <= 1'b1;
               if (wdata_reg[B2_ACQ_TEST]) sh_acq_reg <= 1'b1;
            end
            OFF_BCLR2: begin
               if (wdata_reg[B2_VALID_CTRL]) sh_valid_reg <= 1'b0;
               if (wdata_reg[B2_ACQ_TEST]) begin
                  sh_acq_reg <= 1'b0;
                  tf_cnt_reg <= 6'h00;
               end
            end
            OFF_W_TEST_ADDR: sh_w_reg <= wdata_reg[AW-1:0];
            OFF_R_TEST_ADDR: sh_r_reg <= wdata_reg[AW-1:0];
            OFF_SW_RESET:    sh_valid_reg <= 1'b0;
            // words are counted in load order 0,16,1,17,... as software supplies them
            OFF_TEST_EVENT:  if (tf_cnt_reg != TEST_EVENT_WORDS)
                                tf_cnt_reg <= tf_cnt_reg + 6'h01;
            default:         ;
         endcase
      end
   end
endmodule

// ==== src/acq_link_if.sv ====
// register link between the bus master and the acquisition device
`timescale 1ns/1ps
interface acq_link_if;
   logic        req;
   logic        wr;
   logic        blt;
   logic        wide;
   logic [15:0] addr;
   logic [31:0] wdata;
   logic        ack;
   logic        berr;
   logic [63:0] rdata;
   modport dev  (input req, wr, blt, wide, addr, wdata, output ack, berr, rdata);
   modport host (output req, wr, blt, wide, addr, wdata, input ack, berr, rdata);
endinterface

// ==== src/acq_pkg.sv ====
// shared constants, register map and types for the event acquisition sequencer and its master
package acq_pkg;
   ////////////////////////////////////////////////////////////////////////////////
   // sizes
   localparam int CHANNELS      = 32;
   localparam int AW            = 11;
   localparam int MEB_DEPTH     = 2048;
   localparam int EVT_MAX_WORDS = 34;
   // a new event is refused unless a whole worst-case event still fits
   localparam logic [AW:0] MEB_FULL_LEVEL   = 12'(MEB_DEPTH - EVT_MAX_WORDS);
   localparam logic [5:0]  TEST_EVENT_WORDS = 6'h20;

   ////////////////////////////////////////////////////////////////////////////////
   // timing
   localparam int         CLK_PERIOD_NS = 10;
   localparam int         TAC_TIME_NS   = 1200;
   localparam logic [7:0] TAC_CYCLES    = 8'((TAC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

   ////////////////////////////////////////////////////////////////////////////////
   // device register offsets
   localparam logic [15:0] OFF_BUFFER_LAST = 16'h07fc;
   localparam logic [15:0] OFF_STATUS      = 16'h100e;
   localparam logic [15:0] OFF_CTRL1       = 16'h1010;
   localparam logic [15:0] OFF_SW_RESET    = 16'h1016;
   localparam logic [15:0] OFF_EVT_CNT     = 16'h1024;
   localparam logic [15:0] OFF_BSET2       = 16'h1032;
   localparam logic [15:0] OFF_BCLR2       = 16'h1034;
   localparam logic [15:0] OFF_W_TEST_ADDR = 16'h1036;
   localparam logic [15:0] OFF_TEST_HIGH   = 16'h1038;
   localparam logic [15:0] OFF_TEST_LOW    = 16'h103a;
   localparam logic [15:0] OFF_TEST_EVENT  = 16'h103e;
   localparam logic [15:0] OFF_THRESHOLD   = 16'h1060;
   localparam logic [15:0] OFF_R_TEST_ADDR = 16'h1064;
   localparam logic [15:0] OFF_KILL_MASK   = 16'h1080;

   // second configuration set register bits
   localparam int B2_MEM_TEST     = 0;
   localparam int B2_OVF_SUP_OFF  = 3;
   localparam int B2_ZERO_SUP_OFF = 4;
   localparam int B2_VALID_CTRL   = 5;
   localparam int B2_ACQ_TEST     = 6;
   localparam int B2_EMPTY_WRITE  = 12;
   localparam int B2_COUNT_ALL    = 14;
   // first control register bits
   localparam int C1_BLOCK_END    = 2;
   localparam int C1_BUS_ERROR    = 5;

   localparam logic [15:0] BSET2_RESET = 16'h0000;
   localparam logic [15:0] CTRL1_RESET = 16'h0000;
   localparam logic [7:0]  THR_RESET   = 8'h00;

   ////////////////////////////////////////////////////////////////////////////////
   // buffer word types, bits 26:24
   localparam logic [2:0]  WT_DATA        = 3'h0;
   localparam logic [2:0]  WT_HEADER      = 3'h2;
   localparam logic [2:0]  WT_EOB         = 3'h4;
   localparam logic [2:0]  WT_NOT_VALID   = 3'h6;
   localparam logic [31:0] NOT_VALID_WORD = {5'h00, WT_NOT_VALID, 24'h000000};

   ////////////////////////////////////////////////////////////////////////////////
   // master-side apb register offsets and command bits
   localparam logic [7:0] H_MODE   = 8'h00;
   localparam logic [7:0] H_CMD    = 8'h04;
   localparam logic [7:0] H_ADDR   = 8'h08;
   localparam logic [7:0] H_WDATA  = 8'h0c;
   localparam logic [7:0] H_RD_LO  = 8'h10;
   localparam logic [7:0] H_RD_HI  = 8'h14;
   localparam logic [7:0] H_STATUS = 8'h18;
   localparam int         HM_BLT   = 0;
   localparam int         HM_WIDE  = 1;

   typedef enum logic [2:0] {S_IDLE, S_TAC, S_DIGI, S_HDR, S_DATA, S_EOB, S_CLEAR} seq_state_t;
endpackage
